// ---- shared/hostbus_pkg.sv ----
/*
 Shared constants of the display host bus: modes, pin positions,
 timing counts. Assumes one 25 MHz system clock at each end.
*/
package hostbus_pkg;
	typedef enum logic [1:0] {
		MODE_STROBE_DIR,
		MODE_SEP_STROBE,
		MODE_SERIAL4,
		MODE_SERIAL3
	} bus_mode_t;

	localparam int CLK_NS = 40;
	localparam int CLK_KHZ = 25_000;
	localparam int STARTUP_MS = 200;
	// least time, rounded up
	localparam int STARTUP_CYC = STARTUP_MS * CLK_KHZ;
	// one strobe or serial clock phase
	localparam int PHASE_NS = 320;
	localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 23;

	// positions inside the synchronised pin vector
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_RD = 8;
	localparam int PIN_WR = 9;
	localparam int PIN_DC = 10;
	localparam int PIN_CS = 11;
	localparam int PIN_RES = 12;
	localparam int PIN_W = 13;
	localparam logic [12:0] PIN_IDLE = 13'h1_800;

	localparam logic [3:0] BITS_SER4 = 4'h8;
	localparam logic [3:0] BITS_SER3 = 4'h9;
	localparam logic [7:0] DUMMY_BYTE = 8'h00;
	localparam logic [7:0] SER_RD_BYTE = 8'h00;
	localparam logic [7:0] OE_ALL = 8'hFF;
	localparam logic [7:0] OE_SERIAL = 8'h03;
endpackage

// ---- shared/disp_bus_if.sv ----
/*
 Pin bundle between the host end and the display end.
 The data wire resolves from the enables; undriven bits read low,
 as if tied to ground.
*/
`timescale 1ns/1ns
interface disp_bus_if;
	logic [7:0] host_d_o;
	logic [7:0] host_d_oe;
	logic [7:0] dev_d_o;
	logic dev_d_oe;
	logic [7:0] d_bus;
	logic rd_e;
	logic wr_rw;
	logic dc;
	logic cs_n;
	logic res_n;

	assign d_bus = dev_d_oe ? dev_d_o : (host_d_o & host_d_oe);

	modport dev (
		input d_bus, rd_e, wr_rw, dc, cs_n, res_n,
		output dev_d_o, dev_d_oe
	);
	modport host (
		input d_bus,
		output host_d_o, host_d_oe, rd_e, wr_rw, dc, cs_n, res_n
	);
endinterface

// ---- logic/disp_dev_port.sv ----
/*
 Display end of the host bus: decodes the four bus modes into a
 stream of command/data bytes, and answers status and data reads in the two parallel modes.
 Assumes all bus pins are asynchronous to MCLK and that the host
 holds each strobe phase for several MCLK cycles.
*/
// Notes on behaviour
// - parallel modes move bytes on eight-bit bus
// - direction low writes, high reads
// - select low command/status, high display data
// - latch on enable fall, chip selected
// - read strobe rise completes read
// - write strobe rise latches byte
// - first display-data read is a dummy
// - 4-wire: bit0 clock, bit1 data
// - 4-wire: host leaves bit2 open
// - 3-wire: clock, data, chip select only
// - 3-wire: host leaves bit2 open
// - host start-up: reset high, low, high
// - command byte then its parameter bytes
// - reset input low initialises controller
// - ignore bus unless chip selected
`timescale 1ns/1ns
module disp_dev_port (
	input wire logic MCLK, // system clock
	input wire logic RST, // synchronous reset, high
	disp_bus_if.dev BUS, // host-facing pins
	input wire hostbus_pkg::bus_mode_t MODE, // bus mode strap
	output logic [7:0] WR_BYTE, // received byte
	output logic WR_IS_DATA, // byte is display data
	output logic WR_STB, // one-cycle byte strobe
	output logic RD_ADV, // one-cycle read advance
	input wire logic [7:0] RD_DATA, // display data to read
	input wire logic [7:0] STATUS, // status byte
	output logic INIT // controller initialising
);
	logic [12:0] pins;
	logic [12:0] meta_r;
	logic [12:0] sync_r;
	logic [12:0] prev_r;
	logic in_init;
	logic cs_act;
	logic par_mode;
	logic ser_mode;
	logic e_fall;
	logic rd_rise;
	logic wr_rise;
	logic sclk_rise;
	logic par_wr;
	logic par_rd;
	logic drive;
	logic [3:0] nbits;
	logic [8:0] shift_r;
	logic [3:0] cnt_r;
	logic [7:0] rd_buf_r;
	logic [7:0] d_o_r;
	logic d_oe_r;
	logic [7:0] wr_byte_r;
	logic wr_data_r;
	logic wr_stb_r;
	logic rd_adv_r;
	logic init_r;

	assign pins = {BUS.res_n, BUS.cs_n, BUS.dc, BUS.wr_rw, BUS.rd_e,
		BUS.d_bus};

	// two stages before any logic; prev_r feeds the edge finders
	always_ff @(posedge MCLK) begin
		if (RST) begin
			meta_r <= hostbus_pkg::PIN_IDLE;
			sync_r <= hostbus_pkg::PIN_IDLE;
			prev_r <= hostbus_pkg::PIN_IDLE;
		end else begin
			meta_r <= pins;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign in_init = !sync_r[hostbus_pkg::PIN_RES];
	assign cs_act = !sync_r[hostbus_pkg::PIN_CS] && !in_init;
	assign par_mode = (MODE == hostbus_pkg::MODE_STROBE_DIR) ||
		(MODE == hostbus_pkg::MODE_SEP_STROBE);
	assign ser_mode = !par_mode;

	assign e_fall = prev_r[hostbus_pkg::PIN_RD] &&
		!sync_r[hostbus_pkg::PIN_RD];
	assign rd_rise = !prev_r[hostbus_pkg::PIN_RD] &&
		sync_r[hostbus_pkg::PIN_RD];
	assign wr_rise = !prev_r[hostbus_pkg::PIN_WR] &&
		sync_r[hostbus_pkg::PIN_WR];
	assign sclk_rise = !prev_r[hostbus_pkg::PIN_SCLK] &&
		sync_r[hostbus_pkg::PIN_SCLK];

	// parallel transfer decode
	always_comb begin
		par_wr = 1'b0;
		par_rd = 1'b0;
		drive = 1'b0;
		if (cs_act) begin
			unique case (MODE)
				hostbus_pkg::MODE_STROBE_DIR: begin
					par_wr = e_fall && !sync_r[hostbus_pkg::PIN_WR];
					par_rd = e_fall && sync_r[hostbus_pkg::PIN_WR];
					drive = sync_r[hostbus_pkg::PIN_WR] &&
						sync_r[hostbus_pkg::PIN_RD];
				end
				hostbus_pkg::MODE_SEP_STROBE: begin
					par_wr = wr_rise;
					par_rd = rd_rise;
					drive = !sync_r[hostbus_pkg::PIN_RD];
				end
				hostbus_pkg::MODE_SERIAL4,
				hostbus_pkg::MODE_SERIAL3: begin
					par_wr = 1'b0;
					par_rd = 1'b0;
					drive = 1'b0;
				end
			endcase
		end
	end

	// the leading select bit makes the 3-wire frame one bit longer
	assign nbits = (MODE == hostbus_pkg::MODE_SERIAL3) ?
		hostbus_pkg::BITS_SER3 : hostbus_pkg::BITS_SER4;

	// serial shifter; a deselect drops a partial byte
	always_ff @(posedge MCLK) begin
		if (RST || !cs_act || par_mode) begin
			shift_r <= 9'h000;
			cnt_r <= 4'h0;
		end else if (sclk_rise) begin
			shift_r <= {shift_r[7:0],
				sync_r[hostbus_pkg::PIN_SDATA]};
			if (cnt_r == nbits - 4'h1) begin
				cnt_r <= 4'h0;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end

	// byte output from either path
	always_ff @(posedge MCLK) begin
		if (RST) begin
			wr_byte_r <= 8'h00;
			wr_data_r <= 1'b0;
			wr_stb_r <= 1'b0;
		end else begin
			wr_stb_r <= 1'b0;
			if (par_mode && par_wr) begin
				wr_byte_r <= sync_r[7:0];
				wr_data_r <= sync_r[hostbus_pkg::PIN_DC];
				wr_stb_r <= 1'b1;
			end else if (ser_mode && cs_act && sclk_rise &&
					cnt_r == nbits - 4'h1) begin
				wr_byte_r <= {shift_r[6:0], sync_r[hostbus_pkg::PIN_SDATA]};
				if (MODE == hostbus_pkg::MODE_SERIAL3) begin
					wr_data_r <= shift_r[7];
				end else begin
					wr_data_r <= sync_r[hostbus_pkg::PIN_DC];
				end
				wr_stb_r <= 1'b1;
			end
		end
	end

	// read pipeline: each data read returns the byte fetched by the
	// previous one, so the first after a command is the dummy
	always_ff @(posedge MCLK) begin
		if (RST || in_init) begin
			rd_buf_r <= hostbus_pkg::DUMMY_BYTE;
			rd_adv_r <= 1'b0;
		end else begin
			rd_adv_r <= 1'b0;
			if (par_mode && par_rd && sync_r[hostbus_pkg::PIN_DC]) begin
				rd_buf_r <= RD_DATA;
				rd_adv_r <= 1'b1;
			end else if (par_mode && par_wr &&
					!sync_r[hostbus_pkg::PIN_DC]) begin
				rd_buf_r <= hostbus_pkg::DUMMY_BYTE;
			end
		end
	end

	// bus drive; lags the strobe by three cycles of sync and flop
	always_ff @(posedge MCLK) begin
		if (RST) begin
			d_o_r <= 8'h00;
			d_oe_r <= 1'b0;
		end else begin
			d_oe_r <= par_mode && drive;
			if (sync_r[hostbus_pkg::PIN_DC]) begin
				d_o_r <= rd_buf_r;
			end else begin
				d_o_r <= STATUS;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			init_r <= 1'b1;
		end else begin
			init_r <= in_init;
		end
	end

	assign BUS.dev_d_o = d_o_r;
	assign BUS.dev_d_oe = d_oe_r;
	assign WR_BYTE = wr_byte_r;
	assign WR_IS_DATA = wr_data_r;
	assign WR_STB = wr_stb_r;
	assign RD_ADV = rd_adv_r;
	assign INIT = init_r;
endmodule // disp_dev_port

// ---- logic/disp_host_port.sv ----
/*
 Host end of the display bus: runs the reset start-up, then turns
 byte requests into bus cycles in the selected mode, except serial-mode reads.
 Assumes the display end samples every pin with its own clock.
*/
`timescale 1ns/1ns
module disp_host_port #(
	parameter int STARTUP_CYCLES = hostbus_pkg::STARTUP_CYC
) (
	input wire logic MCLK, // system clock
	input wire logic RST, // synchronous reset, high
	disp_bus_if.host BUS, // display-facing pins
	input wire hostbus_pkg::bus_mode_t MODE, // bus mode
	input wire logic CMD_VALID, // request present
	output logic CMD_READY, // request taken
	input wire logic CMD_READ, // request is a read
	input wire logic CMD_IS_DATA, // data, not command
	input wire logic [7:0] CMD_BYTE, // byte to write
	output logic RSP_VALID, // one-cycle read answer
	output logic [7:0] RSP_BYTE, // byte read
	output logic LINK_UP // start-up finished
);
	typedef enum {
		ST_RES_HI, ST_RES_LO, ST_RES_WAIT, ST_IDLE, ST_ASSERT,
		ST_ACTIVE, ST_BIT_LO, ST_BIT_HI, ST_RELEASE, ST_END
	} host_st_t;

	localparam logic [22:0] PH_LOAD = 23'(hostbus_pkg::PHASE_CYC - 1);
	localparam logic [22:0] SU_LOAD = 23'(STARTUP_CYCLES - 1);

	host_st_t st_r;
	logic [22:0] tmr_r;
	logic done;
	logic serial;
	logic sep;
	logic [8:0] sh_r;
	logic [3:0] bits_r;
	logic rd_r;
	logic [7:0] hmeta_r;
	logic [7:0] hsync_r;
	logic [7:0] d_o_r;
	logic [7:0] d_oe_r;
	logic rd_e_r;
	logic wr_rw_r;
	logic dc_r;
	logic cs_n_r;
	logic res_n_r;
	logic rsp_v_r;
	logic [7:0] rsp_r;

	assign done = (tmr_r == 23'h00_0000);
	assign serial = (MODE == hostbus_pkg::MODE_SERIAL4) ||
		(MODE == hostbus_pkg::MODE_SERIAL3);
	assign sep = (MODE == hostbus_pkg::MODE_SEP_STROBE);

	// read data arrives from the far end's clock
	always_ff @(posedge MCLK) begin
		if (RST) begin
			hmeta_r <= 8'h00;
			hsync_r <= 8'h00;
		end else begin
			hmeta_r <= BUS.d_bus;
			hsync_r <= hmeta_r;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			st_r <= ST_RES_HI;
			tmr_r <= SU_LOAD;
			res_n_r <= 1'b1;
			cs_n_r <= 1'b1;
			dc_r <= 1'b0;
			rd_e_r <= 1'b0;
			wr_rw_r <= 1'b1;
			d_o_r <= 8'h00;
			d_oe_r <= 8'h00;
			sh_r <= 9'h000;
			bits_r <= 4'h0;
			rd_r <= 1'b0;
			rsp_v_r <= 1'b0;
			rsp_r <= 8'h00;
		end else begin
			rsp_v_r <= 1'b0;
			if (!done) begin
				tmr_r <= tmr_r - 23'h00_0001;
			end
			unique case (st_r)
				ST_RES_HI: if (done) begin
					res_n_r <= 1'b0;
					tmr_r <= SU_LOAD;
					st_r <= ST_RES_LO;
				end
				ST_RES_LO: if (done) begin
					res_n_r <= 1'b1;
					tmr_r <= SU_LOAD;
					st_r <= ST_RES_WAIT;
				end
				ST_RES_WAIT: if (done) begin
					st_r <= ST_IDLE;
				end
				ST_IDLE: begin
					// strobes idle inactive; tied low in serial modes
					rd_e_r <= sep;
					wr_rw_r <= sep;
					if (CMD_VALID && serial && CMD_READ) begin
						rsp_v_r <= 1'b1;
						rsp_r <= hostbus_pkg::SER_RD_BYTE;
					end else if (CMD_VALID) begin
						rd_r <= CMD_READ;
						cs_n_r <= 1'b0;
						dc_r <= (MODE == hostbus_pkg::MODE_SERIAL3) ?
							1'b0 : CMD_IS_DATA;
						sh_r <= (MODE == hostbus_pkg::MODE_SERIAL3) ?
							{CMD_IS_DATA, CMD_BYTE} : {CMD_BYTE, 1'b0};
						bits_r <= (MODE == hostbus_pkg::MODE_SERIAL3) ?
							hostbus_pkg::BITS_SER3 : hostbus_pkg::BITS_SER4;
						if (serial) begin
							d_o_r <= 8'h00;
							d_oe_r <= hostbus_pkg::OE_SERIAL;
							rd_e_r <= 1'b0;
							wr_rw_r <= 1'b0;
						end else begin
							d_o_r <= CMD_BYTE;
							d_oe_r <= CMD_READ ? 8'h00 : hostbus_pkg::OE_ALL;
							if (!sep) begin
								wr_rw_r <= CMD_READ;
							end
						end
						tmr_r <= PH_LOAD;
						st_r <= ST_ASSERT;
					end
				end
				ST_ASSERT: if (done) begin
					tmr_r <= PH_LOAD;
					if (serial) begin
						d_o_r[hostbus_pkg::PIN_SCLK] <= 1'b0;
						d_o_r[hostbus_pkg::PIN_SDATA] <= sh_r[8];
						sh_r <= {sh_r[7:0], 1'b0};
						bits_r <= bits_r - 4'h1;
						st_r <= ST_BIT_LO;
					end else begin
						if (!sep) begin
							rd_e_r <= 1'b1;
						end else if (rd_r) begin
							rd_e_r <= 1'b0;
						end else begin
							wr_rw_r <= 1'b0;
						end
						st_r <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: if (done) begin
					if (rd_r) begin
						rsp_v_r <= 1'b1;
						rsp_r <= hsync_r;
					end
					// this edge is the one the display latches on
					rd_e_r <= sep;
					wr_rw_r <= sep ? 1'b1 : wr_rw_r;
					tmr_r <= PH_LOAD;
					st_r <= ST_RELEASE;
				end
				ST_BIT_LO: if (done) begin
					d_o_r[hostbus_pkg::PIN_SCLK] <= 1'b1;
					tmr_r <= PH_LOAD;
					st_r <= ST_BIT_HI;
				end
				ST_BIT_HI: if (done) begin
					d_o_r[hostbus_pkg::PIN_SCLK] <= 1'b0;
					tmr_r <= PH_LOAD;
					if (bits_r == 4'h0) begin
						st_r <= ST_RELEASE;
					end else begin
						d_o_r[hostbus_pkg::PIN_SDATA] <= sh_r[8];
						sh_r <= {sh_r[7:0], 1'b0};
						bits_r <= bits_r - 4'h1;
						st_r <= ST_BIT_LO;
					end
				end
				ST_RELEASE: if (done) begin
					cs_n_r <= 1'b1;
					d_oe_r <= 8'h00;
					tmr_r <= PH_LOAD;
					st_r <= ST_END;
				end
				ST_END: if (done) begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	assign CMD_READY = (st_r == ST_IDLE);
	assign LINK_UP = (st_r != ST_RES_HI) && (st_r != ST_RES_LO) &&
		(st_r != ST_RES_WAIT);
	assign RSP_VALID = rsp_v_r;
	assign RSP_BYTE = rsp_r;
	assign BUS.host_d_o = d_o_r;
	assign BUS.host_d_oe = d_oe_r;
	assign BUS.rd_e = rd_e_r;
	assign BUS.wr_rw = wr_rw_r;
	assign BUS.dc = dc_r;
	assign BUS.cs_n = cs_n_r;
	assign BUS.res_n = res_n_r;
endmodule // disp_host_port

// ---- tb/disp_bus_chk.sv ----
/*
 Pin-level checks between the host end and the display end.
 Assumes one shared MCLK and RST, and the 8-cycle strobe phase.
*/
`timescale 1ns/1ns
module disp_bus_chk (
	input wire logic MCLK, // system clock
	input wire logic RST, // synchronous reset, high
	input wire hostbus_pkg::bus_mode_t MODE, // bus mode
	input wire logic [7:0] host_d_oe, // host drive enables
	input wire logic dev_d_oe, // display drive enable
	input wire logic [7:0] d_bus, // resolved data wire
	input wire logic rd_e, // enable or read strobe
	input wire logic wr_rw, // direction or write strobe
	input wire logic dc, // data/command select
	input wire logic cs_n, // chip select, low
	input wire logic res_n // display reset, low
);
	logic ser, ser3, dir, sep;
	assign ser3 = MODE == hostbus_pkg::MODE_SERIAL3;
	assign ser = ser3 || MODE == hostbus_pkg::MODE_SERIAL4;
	assign dir = MODE == hostbus_pkg::MODE_STROBE_DIR;
	assign sep = MODE == hostbus_pkg::MODE_SEP_STROBE;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	// a few cycles of grace: the display sees cs_n through a synchroniser
	dev_sel_drive_a: assert property (cs_n [*4] |-> !dev_d_oe)
		else $error("display drives while deselected");
	bus_clash_a: assert property (dev_d_oe |-> host_d_oe == 8'h00)
		else $error("both ends drive the data wire");
	dir_read_a: assert property (dir && dev_d_oe |-> wr_rw)
		else $error("display drives during a write cycle");
	sep_read_a: assert property (sep && !cs_n && $rose(rd_e) |-> dev_d_oe)
		else $error("read strobe ends with no read data");
	sep_write_a: assert property (sep && $fell(wr_rw) |->
		!cs_n && host_d_oe == 8'hFF)
		else $error("write strobe without select or data");
	e_pulse_a: assert property (dir && $rose(rd_e) |->
		rd_e [*8] ##1 !rd_e)
		else $error("enable pulse length wrong");
	ser_d2_open_a: assert property (ser && !cs_n |-> host_d_oe == 8'h03)
		else $error("serial mode drives unused data bits");
	ser_strobe_a: assert property (ser && !cs_n |-> !rd_e && !wr_rw)
		else $error("parallel strobes active in serial mode");
	ser3_dc_a: assert property (ser3 && !cs_n |-> !dc)
		else $error("select line used in 3-wire mode");
	sclk_phase_a: assert property (ser && !cs_n && $stable(cs_n) &&
		$rose(d_bus[0]) |-> d_bus[0] [*8] ##1 !d_bus[0])
		else $error("serial clock high phase wrong");
	reset_quiet_a: assert property (!res_n |-> cs_n)
		else $error("display selected while in reset");
endmodule // disp_bus_chk

// ---- tb/testbench.sv ----
/*
 Bench joining host end and display end over the pin interface.
 Assumes the 8-cycle strobe phase and a shortened start-up count.
*/
`timescale 1ns/1ns
module testbench;
	localparam int STUP = 20;
	typedef struct packed {
		logic rd;
		logic dat;
		logic [7:0] b;
		logic [7:0] exp;
	} row_t;
	logic mclk = 0;
	logic rst = 1;
	hostbus_pkg::bus_mode_t mode = hostbus_pkg::MODE_STROBE_DIR;
	logic cmd_valid = 0, cmd_read = 0, cmd_is_data = 0;
	logic [7:0] cmd_byte = 8'h00, rd_data = 8'hC3, status = 8'h5A;
	logic cmd_ready, rsp_valid, link_up, wr_is_data, wr_stb, rd_adv, init;
	logic [7:0] rsp_byte, wr_byte, lbus;
	logic [8:0] sh;
	logic sclk_q;
	int n_mismatch = 0, cmp_count = 0, n_stb = 0, n_adv = 0, n_rsp = 0;
	int low_cnt = 0;
	int s_mid = 0;
	// command, two parameters, status, dummy data read, real data read
	row_t rows [6] = '{'{1'b0, 1'b0, 8'hA0, 8'hA0},
		'{1'b0, 1'b1, 8'h14, 8'h14}, '{1'b0, 1'b1, 8'h11, 8'h11},
		'{1'b1, 1'b0, 8'h00, 8'h5A}, '{1'b1, 1'b1, 8'h00, 8'h00},
		'{1'b1, 1'b1, 8'h00, 8'hC3}};

	disp_bus_if bus();
	disp_host_port #(.STARTUP_CYCLES(STUP)) i_disp_host_port (.MCLK(mclk),
		.RST(rst), .BUS(bus), .MODE(mode), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_READ(cmd_read),
		.CMD_IS_DATA(cmd_is_data), .CMD_BYTE(cmd_byte),
		.RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte), .LINK_UP(link_up));
	disp_dev_port i_disp_dev_port (.MCLK(mclk), .RST(rst), .BUS(bus),
		.MODE(mode), .WR_BYTE(wr_byte), .WR_IS_DATA(wr_is_data),
		.WR_STB(wr_stb), .RD_ADV(rd_adv), .RD_DATA(rd_data),
		.STATUS(status), .INIT(init));
	disp_bus_chk i_disp_bus_chk (.MCLK(mclk), .RST(rst), .MODE(mode),
		.host_d_oe(bus.host_d_oe), .dev_d_oe(bus.dev_d_oe),
		.d_bus(bus.d_bus), .rd_e(bus.rd_e), .wr_rw(bus.wr_rw), .dc(bus.dc),
		.cs_n(bus.cs_n), .res_n(bus.res_n));

	always #20 mclk = ~mclk;

	// wire monitor: bytes seen on the bus and bits shifted serially
	always @(posedge mclk) begin
		n_stb <= n_stb + int'(wr_stb === 1'b1);
		n_adv <= n_adv + int'(rd_adv === 1'b1);
		n_rsp <= n_rsp + int'(rsp_valid === 1'b1);
		low_cnt <= rst ? 0 : low_cnt + int'(bus.res_n === 1'b0);
		sclk_q <= bus.d_bus[0];
		if (bus.host_d_oe == 8'hFF)
			lbus <= bus.d_bus;
		if (!bus.cs_n && bus.d_bus[0] && !sclk_q && bus.host_d_oe == 8'h03)
			sh <= {sh[7:0], bus.d_bus[1]};
	end

	task automatic check(input string what, input logic [8:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wait_ready();
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 3000) begin
			@(negedge mclk);
			k++;
		end
		if (k == 3000)
			check("ready", 9'h000, 9'h001);
	endtask

	task automatic start_up();
		int k;
		rst = 1;
		repeat (10) @(negedge mclk);
		check("held", {4'h0, init, link_up, cmd_ready, bus.res_n, bus.cs_n},
			9'h013);
		rst = 0;
		k = 0;
		while (link_up !== 1'b1 && k < 200) begin
			@(negedge mclk);
			k++;
		end
		check("link_up", {8'h00, link_up}, 9'h001);
		check("res_n low", 9'(low_cnt), 9'(STUP));
		check("init", {8'h00, init}, 9'h000);
		$display("start-up test done");
	endtask

	task automatic run_row(input row_t r, input logic ser);
		int s0, a0, r0;
		logic [7:0] e;
		logic s3;
		s0 = n_stb;
		a0 = n_adv;
		r0 = n_rsp;
		s3 = mode == hostbus_pkg::MODE_SERIAL3;
		@(negedge mclk);
		cmd_valid = 1;
		cmd_read = r.rd;
		cmd_is_data = r.dat;
		cmd_byte = r.b;
		wait_ready();
		@(negedge mclk);
		cmd_valid = 0;
		wait_ready();
		// display strobes a few cycles after the last pin edge
		repeat (6) @(negedge mclk);
		e = (ser && r.rd) ? hostbus_pkg::SER_RD_BYTE : r.exp;
		if (r.rd) begin
			check("rsp_byte", {1'b0, rsp_byte}, {1'b0, e});
			check("rsp count", 9'(n_rsp - r0), 9'h001);
			check("rd_adv", 9'(n_adv - a0), 9'(!ser && r.dat));
		end else begin
			check("wr_byte", {wr_is_data, wr_byte}, {r.dat, r.b});
			check("wr count", 9'(n_stb - s0), 9'h001);
			if (!ser)
				check("bus byte", {1'b0, lbus}, {1'b0, r.b});
			else
				check("serial", s3 ? sh : {1'b0, sh[7:0]},
					{s3 & r.dat, r.b});
		end
	endtask

	initial begin
		start_up();
		for (int m = 0; m < 4; m++) begin
			mode = hostbus_pkg::bus_mode_t'(m);
			foreach (rows[i])
				run_row(rows[i], 1'(m >= 2));
			$display("mode %0d rows done", m);
		end
		// reset in mid-byte: the partial byte must never surface
		@(negedge mclk);
		s_mid = n_stb;
		cmd_valid = 1;
		cmd_read = 0;
		cmd_is_data = 1;
		cmd_byte = 8'h5A;
		repeat (60) @(negedge mclk);
		cmd_valid = 0;
		check("stb before", 9'(n_stb - s_mid), 9'h000);
		begin
			int s0;
			s0 = n_stb;
			start_up();
			check("no partial", 9'(n_stb - s0), 9'h000);
		end
		run_row('{1'b0, 1'b1, 8'hFF, 8'hFF}, 1'b1);
		run_row('{1'b0, 1'b0, 8'h00, 8'h00}, 1'b1);
		$display("mid-byte reset test done");
		mode = hostbus_pkg::MODE_STROBE_DIR;
		// read buffer starts empty after reset
		run_row('{1'b1, 1'b1, 8'h00, 8'h00}, 1'b0);
		run_row('{1'b1, 1'b1, 8'h00, 8'hC3}, 1'b0);
		$display("read after reset test done");
		wrap_up();
	end

	// ample margin over roughly 2200 cycles of traffic
	initial begin
		#1000000;
		n_mismatch++;
		wrap_up();
	end
endmodule // testbench
